// *** hdl/loader_defs.svh ***
/*
 * constants of the serial image loader: register map, field positions,
 * reset values, directory layout and serial timing.
 * assumes inclusion by bare name from the loader design files.
 */
`ifndef LOADER_DEFS_SVH
`define LOADER_DEFS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_VER 8'h04
`define REG_STAT 8'h08
`define REG_DIR 8'h0c
// control field positions
`define CTRL_CPOL 0
`define CTRL_CPHA 1
`define CTRL_RECOV 2
`define CTRL_AUTO 3
`define CTRL_BLEN 4
`define CTRL_BYPASS 5
`define CTRL_IAP 8
// control reset values
`define CPOL_RST 1'b1
`define CPHA_RST 1'b1
// flash directory
`define DIR_BASE 24'h000000
`define DIR_LEN 12
`define DIR_GADDR 0
`define DIR_GVER 4
`define DIR_UADDR 6
`define DIR_UVER 10
`define FLASH_READ 8'h03
// serial timing
`define CLK_NS 50
`define SCLK_HALF_NS 300
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// *** hdl/loader_pkg.sv ***
/*
 * types of the serial image loader.
 * assumes nothing of its surroundings.
 */
package loader_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD = 3'b001,
		S_ADDR = 3'b010,
		S_DATA = 3'b011,
		S_DECIDE = 3'b100,
		S_HALT = 3'b101
	} state_type;
endpackage

// *** hdl/spi_link_if.sv ***
/*
 * byte link between the loader sequencer and the serial shifter.
 * assumes both ends run on hclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic start;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic done;
	logic busy;
	logic cpol;
	logic cpha;
	logic miso;
	logic sclk;
	logic mosi;
	modport ctrl(output start, tx_byte, cpol, cpha, miso,
		input rx_byte, done, busy, sclk, mosi);
	modport engine(input start, tx_byte, cpol, cpha, miso,
		output rx_byte, done, busy, sclk, mosi);
endinterface
`default_nettype wire

// *** hdl/pin_sync.sv ***
/*
 * three-stage synchroniser for pins from outside the hclk domain.
 * assumes each output bit changes once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;

	// stage chain, then take a bit only where two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			lvl_q <= INIT;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
		end
	end

	assign level_out = lvl_q;
endmodule // pin_sync
`default_nettype wire

// *** hdl/spi_shifter.sv ***
/*
 * serial master byte shifter with selectable clock polarity and phase.
 * assumes miso arrives already synchronised and start comes only when idle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loader_defs.svh"
module spi_shifter #(
	parameter int HALF = `SCLK_HALF_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	spi_link_if.engine lk
);
	logic [7:0] cnt_q;
	logic half_q;
	logic [2:0] bit_q;
	logic [7:0] sr_q;
	logic [7:0] rx_q;
	logic [7:0] rxo_q;
	logic busy_q;
	logic done_q;
	logic sclk_q;
	logic mosi_q;
	logic samp_q;
	logic edge_now;

	assign edge_now = busy_q && (cnt_q == 8'(HALF - 1));

	// half-period timer and edge sequencing; the loader is always master
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 8'h00;
			half_q <= 1'b0;
			bit_q <= 3'h0;
			sr_q <= 8'h00;
			rx_q <= 8'h00;
			rxo_q <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			sclk_q <= `CPOL_RST;
			mosi_q <= 1'b0;
			samp_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			samp_q <= 1'b0;
			if (!busy_q) begin
				sclk_q <= lk.cpol;
				if (lk.start) begin
					busy_q <= 1'b1;
					sr_q <= lk.tx_byte;
					cnt_q <= 8'h00;
					half_q <= 1'b0;
					bit_q <= 3'h0;
					if (!lk.cpha)
						mosi_q <= lk.tx_byte[7];
				end
			end else if (!edge_now) begin
				cnt_q <= cnt_q + 8'h01;
			end else begin
				cnt_q <= 8'h00;
				sclk_q <= ~sclk_q;
				half_q <= ~half_q;
				// leading edge samples for phase zero, shifts for phase one
				if (!half_q) begin
					if (lk.cpha) begin
						mosi_q <= sr_q[7];
						sr_q <= {sr_q[6:0], 1'b0};
					end else begin
						rx_q <= {rx_q[6:0], lk.miso};
						samp_q <= 1'b1;
					end
				end else begin
					if (lk.cpha) begin
						rx_q <= {rx_q[6:0], lk.miso};
						samp_q <= 1'b1;
					end else begin
						mosi_q <= sr_q[6];
						sr_q <= {sr_q[6:0], 1'b0};
					end
					bit_q <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
						rxo_q <= lk.cpha ? {rx_q[6:0], lk.miso} : rx_q;
					end
				end
			end
		end
	end

	assign lk.busy = busy_q;
	assign lk.done = done_q;
	assign lk.rx_byte = rxo_q;
	assign lk.sclk = sclk_q;
	assign lk.mosi = mosi_q;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// clock rests at the polarity level between bytes
	sclk_idle_a: assert property (
		(!busy_q ##1 !busy_q) |-> sclk_q == $past(lk.cpol))
		else $error("serial clock not at idle level");

	// sampling edge direction follows polarity versus phase
	sample_edge_a: assert property (
		samp_q |-> sclk_q == (lk.cpol == lk.cpha))
		else $error("data sampled on wrong clock edge");
endmodule // spi_shifter
`default_nettype wire

// *** hdl/spi_image_recovery_loader.sv ***
/*
 * serial image loader: reads the flash directory and streams the golden or
 * update image to the programming logic, with recovery and version gating.
 * assumes an ahb-lite master on hclk and a serial flash on the spi pins.
 */
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "loader_defs.svh"
module spi_image_recovery_loader #(
	parameter int IMAGE_BYTES = 256
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic device_reset_n,
	input wire logic golden_sel_n,
	input wire logic prog_interrupted,
	input wire logic spi_miso,
	output logic spi_sclk,
	output logic spi_mosi,
	output logic spi_cs_n,
	output logic [7:0] prog_data,
	output logic prog_valid,
	output logic prog_master
);
	spi_link_if lk();
	loader_pkg::state_type state_q;
	logic [3:0] pins_s;
	logic devrst_s;
	logic golden_sel_s;
	logic interrupted_s;
	logic [2:0] settle_q;
	logic devrst_prev_q;
	// bus side
	logic wr_q;
	logic [7:0] wa_q;
	logic [31:0] hrdata_q;
	// settings
	logic cpol_q;
	logic cpha_q;
	logic recov_q;
	logic auto_q;
	logic bl_en_q;
	logic bypass_q;
	logic cfg_seen_q;
	logic [15:0] dver_q;
	logic [15:0] backlevel_q;
	// sequencer
	logic boot_pend_q;
	logic iap_pend_q;
	logic iap_kind_q;
	logic dir_txn_q;
	logic golden_q;
	logic halted_q;
	logic reject_q;
	logic [23:0] addr_q;
	logic [15:0] img_ver_q;
	logic [23:0] idx_q;
	logic [7:0] dir_q [0:`DIR_LEN-1];
	logic start_q;
	logic [7:0] tx_q;
	logic cs_n_q;
	logic [7:0] prog_data_q;
	logic prog_valid_q;
	logic prog_master_q;
	// directory decode
	logic [15:0] gver;
	logic [15:0] uver;
	logic [31:0] gaddr;
	logic [31:0] uaddr;
	logic recov_eff;
	logic go_golden;
	logic golden_blocked;
	logic upd_ok;
	logic last_byte;

	// pin synchronisers, idle levels at reset
	pin_sync #(.W(4), .INIT(4'h3)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin_in({spi_miso, prog_interrupted, golden_sel_n, device_reset_n}),
		.level_out(pins_s)
	);
	assign devrst_s = pins_s[0];
	assign golden_sel_s = pins_s[1];
	assign interrupted_s = pins_s[2];

	spi_shifter u_shift (
		.hclk(hclk),
		.hresetn(hresetn),
		.lk(lk)
	);
	assign lk.start = start_q;
	assign lk.tx_byte = tx_q;
	assign lk.cpol = cpol_q;
	assign lk.cpha = cpha_q;
	assign lk.miso = pins_s[3];

	// register read decode
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		case (a)
			`REG_CTRL: rd_mux = {26'h0, bypass_q, bl_en_q, auto_q, recov_eff,
				cpha_q, cpol_q};
			`REG_VER: rd_mux = {backlevel_q, dver_q};
			`REG_STAT: rd_mux = {24'h0, reject_q, halted_q, golden_q,
				lk.busy, 1'b0, state_q};
			`REG_DIR: rd_mux = {uver, gver};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	// ahb-lite slave, zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			hrdata_q <= 32'h0;
		end else begin
			wr_q <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				wr_q <= hwrite && (hsize == 3'b010);
				wa_q <= haddr[7:0];
				if (!hwrite)
					hrdata_q <= rd_mux(haddr[7:0]);
			end
		end
	end
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// settings other than dver_q come only over the bus, never from an image
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpol_q <= `CPOL_RST;
			cpha_q <= `CPHA_RST;
			recov_q <= 1'b0;
			auto_q <= 1'b0;
			bl_en_q <= 1'b0;
			bypass_q <= 1'b1;
			cfg_seen_q <= 1'b0;
			backlevel_q <= 16'h0000;
		end else if (wr_q && wa_q == `REG_CTRL) begin
			cpol_q <= hwdata[`CTRL_CPOL];
			cpha_q <= hwdata[`CTRL_CPHA];
			recov_q <= hwdata[`CTRL_RECOV];
			auto_q <= hwdata[`CTRL_AUTO];
			bl_en_q <= hwdata[`CTRL_BLEN];
			bypass_q <= hwdata[`CTRL_BYPASS];
			cfg_seen_q <= 1'b1;
		end else if (wr_q && wa_q == `REG_VER) begin
			backlevel_q <= hwdata[31:16];
		end
	end
	assign recov_eff = recov_q | auto_q;

	// boot and reprogram requests; a new request beats the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settle_q <= 3'h0;
			devrst_prev_q <= 1'b1;
			boot_pend_q <= 1'b1;
			iap_pend_q <= 1'b0;
		end else begin
			settle_q <= {settle_q[1:0], 1'b1};
			devrst_prev_q <= devrst_s;
			if (state_q == loader_pkg::S_IDLE && settle_q[2] && boot_pend_q)
				boot_pend_q <= 1'b0;
			else if (state_q == loader_pkg::S_IDLE && iap_pend_q)
				iap_pend_q <= 1'b0;
			if (devrst_prev_q && !devrst_s)
				boot_pend_q <= 1'b1;
			if (wr_q && wa_q == `REG_CTRL && hwdata[`CTRL_IAP])
				iap_pend_q <= 1'b1;
		end
	end

	// directory fields, versions low byte first
	assign gaddr = {dir_q[`DIR_GADDR+3], dir_q[`DIR_GADDR+2],
		dir_q[`DIR_GADDR+1], dir_q[`DIR_GADDR]};
	assign gver = {dir_q[`DIR_GVER+1], dir_q[`DIR_GVER]};
	assign uaddr = {dir_q[`DIR_UADDR+3], dir_q[`DIR_UADDR+2],
		dir_q[`DIR_UADDR+1], dir_q[`DIR_UADDR]};
	assign uver = {dir_q[`DIR_UVER+1], dir_q[`DIR_UVER]};

	// image choice after the directory is read
	assign go_golden = !iap_kind_q && interrupted_s && recov_eff;
	assign golden_blocked = bl_en_q && !bypass_q && (gver <= backlevel_q);
	assign upd_ok = (!bl_en_q || uver > backlevel_q)
		&& (iap_kind_q || (auto_q && uver > dver_q));
	assign last_byte = dir_txn_q ? (idx_q == 24'(`DIR_LEN - 1))
		: (idx_q == 24'(IMAGE_BYTES - 1));

	// transfer sequencer: command, three address bytes, data frames
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= loader_pkg::S_IDLE;
			iap_kind_q <= 1'b0;
			dir_txn_q <= 1'b0;
			golden_q <= 1'b0;
			halted_q <= 1'b0;
			reject_q <= 1'b0;
			addr_q <= 24'h0;
			img_ver_q <= 16'h0;
			idx_q <= 24'h0;
			start_q <= 1'b0;
			tx_q <= 8'h00;
			cs_n_q <= 1'b1;
			dver_q <= 16'h0000;
			prog_data_q <= 8'h00;
			prog_valid_q <= 1'b0;
			prog_master_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			prog_valid_q <= 1'b0;
			if (wr_q && wa_q == `REG_VER)
				dver_q <= hwdata[15:0];
			case (state_q)
				loader_pkg::S_IDLE: begin
					// master flag held one cycle past the data state to cover the last byte
					prog_master_q <= 1'b0;
					if ((settle_q[2] && boot_pend_q && !golden_sel_s) ||
						(!(settle_q[2] && boot_pend_q) && iap_pend_q)) begin
						iap_kind_q <= !(settle_q[2] && boot_pend_q);
						dir_txn_q <= 1'b1;
						addr_q <= `DIR_BASE;
						state_q <= loader_pkg::S_CMD;
						cs_n_q <= 1'b0;
						start_q <= 1'b1;
						tx_q <= `FLASH_READ;
					end
				end
				loader_pkg::S_CMD: begin
					if (lk.done) begin
						state_q <= loader_pkg::S_ADDR;
						idx_q <= 24'h0;
						start_q <= 1'b1;
						tx_q <= addr_q[23:16];
					end
				end
				loader_pkg::S_ADDR: begin
					if (lk.done) begin
						start_q <= 1'b1;
						if (idx_q == 24'h2) begin
							state_q <= loader_pkg::S_DATA;
							idx_q <= 24'h0;
							tx_q <= 8'h00;
							prog_master_q <= !dir_txn_q && golden_q;
						end else begin
							idx_q <= idx_q + 24'h1;
							tx_q <= (idx_q == 24'h0) ? addr_q[15:8] : addr_q[7:0];
						end
					end
				end
				loader_pkg::S_DATA: begin
					if (lk.done) begin
						if (dir_txn_q)
							dir_q[idx_q[3:0]] <= lk.rx_byte;
						else begin
							prog_data_q <= lk.rx_byte;
							prog_valid_q <= 1'b1;
						end
						if (last_byte) begin
							cs_n_q <= 1'b1;
							if (dir_txn_q)
								state_q <= loader_pkg::S_DECIDE;
							else begin
								state_q <= loader_pkg::S_IDLE;
								dver_q <= img_ver_q;
							end
						end else begin
							idx_q <= idx_q + 24'h1;
							start_q <= 1'b1;
						end
					end
				end
				loader_pkg::S_DECIDE: begin
					dir_txn_q <= 1'b0;
					reject_q <= 1'b0;
					// image source is always the boot serial port
					if (go_golden && golden_blocked) begin
						state_q <= loader_pkg::S_HALT;
						halted_q <= 1'b1;
					end else if (go_golden || upd_ok) begin
						golden_q <= go_golden;
						addr_q <= go_golden ? gaddr[23:0] : uaddr[23:0];
						img_ver_q <= go_golden ? gver : uver;
						state_q <= loader_pkg::S_CMD;
						cs_n_q <= 1'b0;
						start_q <= 1'b1;
						tx_q <= `FLASH_READ;
					end else begin
						reject_q <= iap_kind_q || auto_q;
						state_q <= loader_pkg::S_IDLE;
					end
				end
				loader_pkg::S_HALT: begin
					cs_n_q <= 1'b1;
				end
				default: state_q <= loader_pkg::S_IDLE;
			endcase
		end
	end

	assign spi_sclk = lk.sclk;
	assign spi_mosi = lk.mosi;
	assign spi_cs_n = cs_n_q;
	assign prog_data = prog_data_q;
	assign prog_valid = prog_valid_q;
	assign prog_master = prog_master_q;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence boot_req_s;
		state_q == loader_pkg::S_IDLE && settle_q[2] && boot_pend_q && !golden_sel_s;
	endsequence
	sequence golden_refused_s;
		state_q == loader_pkg::S_DECIDE && go_golden && golden_blocked;
	endsequence

	boot_start_a: assert property (
		boot_req_s |=> state_q == loader_pkg::S_CMD && !cs_n_q && start_q
			&& tx_q == `FLASH_READ)
		else $error("boot did not start flash read");

	halt_entry_a: assert property (
		golden_refused_s |=> state_q == loader_pkg::S_HALT ##1 cs_n_q)
		else $error("blocked golden recovery did not halt");

	cs_frame_a: assert property (
		cs_n_q == !(state_q inside {loader_pkg::S_CMD, loader_pkg::S_ADDR,
			loader_pkg::S_DATA}))
		else $error("select level wrong for frame state");

	addr_order_a: assert property (
		(state_q == loader_pkg::S_CMD && lk.done) |=> start_q && tx_q == addr_q[23:16])
		else $error("address not issued msb first");

	cfg_blank_a: assert property (
		!cfg_seen_q |-> cpol_q && cpha_q)
		else $error("blank clock mode not one and one");

	update_gate_a: assert property (
		(prog_valid_q && !golden_q && !iap_kind_q) |-> auto_q && img_ver_q > $past(dver_q))
		else $error("update image programmed without newer version");

	backlevel_gate_a: assert property (
		(prog_valid_q && !golden_q && bl_en_q) |-> img_ver_q > backlevel_q)
		else $error("image not above back-level programmed");

	master_only_a: assert property (
		prog_master_q |-> golden_q && !dir_txn_q
			&& (state_q == loader_pkg::S_DATA || prog_valid_q))
		else $error("master flag raised for non-master image");
endmodule // spi_image_recovery_loader
`default_nettype wire

// *** testbench/spi_flash_model.sv ***
/*
 * serial flash model: takes a read command and a 24-bit address, then
 * streams bytes from its array. assumes the bench sets the mode inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_flash_model (
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic cpol,
	input wire logic cpha,
	output logic spi_miso,
	output logic [7:0] last_cmd,
	output logic [31:0] last_addr
);
	logic [7:0] mem [0:1023]; // directory from byte zero
	logic [31:0] hdr = 32'h0;
	int nbit = 0;
	// bit due on the line; header bytes carry a moving junk pattern
	function automatic logic out_bit(input int n);
		if (n < 32)
			return (spi_miso === 1'b1) ? 1'b0 : 1'b1;
		return mem[(int'(last_addr[9:0]) + n / 8 - 4) % 1024][7 - n % 8];
	endfunction
	// frame start: first bit ready before a leading sample edge
	always @(negedge spi_cs_n) begin
		nbit = 0;
		spi_miso = out_bit(0);
	end
	// released line no longer shows its last value
	always @(posedge spi_cs_n) begin
		spi_miso = (spi_miso === 1'b1) ? 1'b0 : 1'b1;
	end
	// sample on rising when polarity equals phase, else falling
	always @(spi_sclk) begin
		if (spi_cs_n === 1'b0) begin
			if (spi_sclk === (cpol == cpha)) begin
				hdr = {hdr[30:0], spi_mosi}; // msb first
				nbit++;
				if (nbit == 8)
					last_cmd = hdr[7:0];
				if (nbit == 32)
					last_addr = {8'h00, hdr[23:0]};
			end else
				spi_miso = out_bit(nbit);
		end
	end
endmodule // spi_flash_model
`default_nettype wire

// *** testbench/tb.sv ***
/*
 * bench of the serial image loader: bus tasks, flash model, load runs.
 * assumes the loader defines header is on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loader_defs.svh"
module tb;
	localparam int IMG = 16;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, last_addr, ga, ua;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic device_reset_n = 1'b1, golden_sel_n = 1'b1, prog_interrupted = 1'b0;
	logic hready, hreadyout, hresp, spi_miso, spi_sclk, spi_mosi, spi_cs_n;
	logic prog_valid, prog_master;
	logic [7:0] prog_data, last_cmd;
	logic cpol = 1'b1, cpha = 1'b1, rec = 1'b0, au = 1'b0, blen = 1'b0, byp = 1'b1;
	logic [15:0] gv = 16'h0, uv = 16'h0, bl = 16'h0, dv = 16'h0;
	logic [7:0] pq[$];
	logic mq[$];
	int errors = 0, n_tests = 0, cyc = 0, rises = 0, idle_bad = 0, seed = 41812;

	assign hready = hreadyout;
	spi_image_recovery_loader #(.IMAGE_BYTES(IMG)) spi_image_recovery_loader_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .device_reset_n, .golden_sel_n, .prog_interrupted,
		.spi_miso, .spi_sclk, .spi_mosi, .spi_cs_n, .prog_data, .prog_valid, .prog_master);
	spi_flash_model spi_flash_model_inst (.spi_sclk, .spi_cs_n, .spi_mosi, .cpol, .cpha,
		.spi_miso, .last_cmd, .last_addr);

	// clock and hang limit
	always #25 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			final_report();
		end
	end
	// capture streamed bytes, count frames, watch the idle clock level
	always @(posedge hclk) begin
		if (prog_valid === 1'b1) begin
			pq.push_back(prog_data);
			mq.push_back(prog_master);
		end
		if (spi_cs_n === 1'b1 && spi_sclk !== cpol)
			idle_bad++;
	end
	always @(posedge spi_cs_n) rises++;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one single word transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	function automatic logic [31:0] cfg(input logic in_app_reprogram);
		return {23'h0, in_app_reprogram, 2'b00, byp, blen, au, rec, cpha, cpol};
	endfunction

	// expected result: 0 none, 1 golden, 2 update, 3 halt
	function automatic logic [1:0] outcome(input logic in_app_reprogram);
		if (prog_interrupted && (rec || au) && !in_app_reprogram)
			return (blen && !byp && gv <= bl) ? 2'd3 : 2'd1;
		if ((!blen || uv > bl) && (in_app_reprogram || (au && uv > dv)))
			return 2'd2;
		return 2'd0;
	endfunction

	// random images behind a directory at byte zero
	task automatic prep();
		ga = 32'h100 + ($random(seed) & 32'hff);
		ua = 32'h200 + ($random(seed) & 32'hff);
		for (int i = 12; i < 1024; i++)
			spi_flash_model_inst.mem[i] = 8'($random(seed));
		for (int i = 0; i < 4; i++) begin
			spi_flash_model_inst.mem[i] = ga[8*i +: 8];
			spi_flash_model_inst.mem[6 + i] = ua[8*i +: 8];
		end
		for (int i = 0; i < 2; i++) begin
			spi_flash_model_inst.mem[4 + i] = gv[8*i +: 8];
			spi_flash_model_inst.mem[10 + i] = uv[8*i +: 8];
		end
	endtask

	// one load from request to idle or halt, then all checks
	task automatic load(input logic in_app_reprogram);
		logic [1:0] k;
		logic [31:0] base, st;
		k = outcome(in_app_reprogram);
		prep();
		xfer(1'b1, `REG_CTRL, cfg(1'b0));
		repeat (3) @(posedge hclk);
		idle_bad = 0;
		rises = 0;
		pq.delete();
		mq.delete();
		if (in_app_reprogram)
			xfer(1'b1, `REG_CTRL, cfg(1'b1));
		else begin
			device_reset_n <= 1'b0;
			repeat (8) @(posedge hclk);
			device_reset_n <= 1'b1;
		end
		for (int i = 0; i < 3000; i++) begin
			xfer(1'b0, `REG_STAT, 32'h0);
			if (i > 20 && spi_cs_n === 1'b1 && (rd[2:0] === 3'd0 || rd[2:0] === 3'd5))
				break;
		end
		st = rd;
		check(32'(st[6]), 32'(k == 2'd3));
		if (k == 2'd0)
			check(32'(st[7]), 32'h1);
		check(32'(pq.size()), (k == 2'd1 || k == 2'd2) ? IMG : 0);
		check(32'(rises), (k == 2'd1 || k == 2'd2) ? 2 : 1);
		check(32'(idle_bad), 32'h0);
		xfer(1'b0, `REG_DIR, 32'h0);
		check(rd, {uv, gv});
		if (k == 2'd1 || k == 2'd2) begin
			base = (k == 2'd1) ? ga : ua;
			dv = (k == 2'd1) ? gv : uv;
			check(32'(last_cmd), 32'(`FLASH_READ));
			check(last_addr, {8'h00, base[23:0]});
			for (int i = 0; i < pq.size(); i++) begin
				check(32'(pq[i]), 32'(spi_flash_model_inst.mem[int'(base[9:0]) + i]));
				check(32'(mq[i]), 32'(k == 2'd1));
			end
			xfer(1'b0, `REG_VER, 32'h0);
			check(32'(rd[15:0]), 32'(dv));
		end
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, `REG_CTRL, 32'h0);
		check(rd & 32'h23, 32'h23);
		xfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		rises = 0;
		device_reset_n <= 1'b0;
		repeat (8) @(posedge hclk);
		device_reset_n <= 1'b1;
		repeat (40) @(posedge hclk);
		check(32'(rises), 32'h0);
		xfer(1'b1, `REG_VER, 32'hffffffff);
		xfer(1'b0, `REG_VER, 32'h0);
		check(rd, 32'hffffffff);
		au = 1'b1;
		xfer(1'b1, `REG_CTRL, cfg(1'b0));
		xfer(1'b0, `REG_CTRL, 32'h0);
		check(32'(rd[2]), 32'h1);
		au = 1'b0;
		dv = 16'h0040;
		bl = 16'h1000;
		xfer(1'b1, `REG_VER, {bl, dv});
		// every clock mode with random images
		for (int m = 0; m < 4; m++) begin
			// model mode set at once so the control word written next carries it
			cpol = m[0];
			cpha = m[1];
			gv = 16'($random(seed));
			uv = 16'($random(seed));
			load(1'b1);
		end
		// back-level boundary: equal refused, one above taken
		blen = 1'b1;
		uv = bl;
		load(1'b1);
		uv = bl + 16'h1;
		load(1'b1);
		// auto update at boot: same version ignored, newer taken
		golden_sel_n <= 1'b0;
		blen = 1'b0;
		au = 1'b1;
		uv = dv;
		load(1'b0);
		uv = dv + 16'h1;
		load(1'b0);
		// power loss: bypass lets an old golden image through, else halt
		prog_interrupted <= 1'b1;
		// let the level land before the expectation reads it
		@(posedge hclk);
		au = 1'b0;
		rec = 1'b1;
		blen = 1'b1;
		gv = bl;
		load(1'b0);
		byp = 1'b0;
		load(1'b0);
		final_report();
	end
endmodule // tb
`default_nettype wire
